// ### logic/sld_apb.v
// apb slave register file of the led display block
`timescale 1ns/1ns
`include "sld_consts.vh"
module sld_apb (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire [4:0]  err_code,
  input  wire [7:0]  status_in,
  input  wire [18:0] leds_in,
  input  wire [2:0]  events,
  output reg  [4:0]  ctrl,
  output wire        irq
);
  reg  [2:0] irq_stat;
  reg  [2:0] irq_en;
  wire       wr = psel & penable & pwrite;
  wire       clr_hit = wr && (paddr == `SLD_REG_IRQ_CLR);
  wire       known = (paddr == `SLD_REG_CTRL) || (paddr == `SLD_REG_ERRCODE) ||
                     (paddr == `SLD_REG_STATUS) || (paddr == `SLD_REG_IRQ_STAT) ||
                     (paddr == `SLD_REG_IRQ_EN) || (paddr == `SLD_REG_IRQ_CLR) ||
                     (paddr == `SLD_REG_LEDS);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;
  assign irq     = |(irq_stat & irq_en);
  always @(posedge clk) begin
    if (!rstn) begin
      ctrl     <= `SLD_CTRL_RST;
      irq_en   <= 3'h0;
      irq_stat <= 3'h0;
      prdata   <= 32'h00000000;
    end else begin
      if (wr && paddr == `SLD_REG_CTRL)
        ctrl <= pwdata[4:0];
      if (wr && paddr == `SLD_REG_IRQ_EN)
        irq_en <= pwdata[2:0];
      // set wins over clear
      irq_stat <= (irq_stat & ~(clr_hit ? pwdata[2:0] : 3'h0)) | events;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SLD_REG_CTRL:     prdata <= {27'h0, ctrl};
          `SLD_REG_ERRCODE:  prdata <= {27'h0, err_code};
          `SLD_REG_STATUS:   prdata <= {24'h0, status_in};
          `SLD_REG_IRQ_STAT: prdata <= {29'h0, irq_stat};
          `SLD_REG_IRQ_EN:   prdata <= {29'h0, irq_en};
          `SLD_REG_LEDS:     prdata <= {13'h0, leds_in};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

// ### logic/sld_blink.v
// blink generator: toggles an output every half period
`timescale 1ns/1ns
module sld_blink #(
  parameter HALF = 12500000
) (
  input  wire clk,
  input  wire rstn,
  output reg  blink
);
  reg [31:0] count;
  always @(posedge clk) begin
    if (!rstn) begin
      count <= 32'h00000000;
      blink <= 1'b0;
    end else if (count >= HALF - 1) begin
      count <= 32'h00000000;
      blink <= ~blink;
    end else begin
      count <= count + 32'h00000001;
    end
  end
endmodule

// ### logic/sld_consts.vh
// constants of the status led display block
`ifndef SLD_CONSTS_VH
`define SLD_CONSTS_VH
`define SLD_CLK_HZ        25000000
`define SLD_SLOW_PERIOD_MS 1000
`define SLD_FAST_PERIOD_MS 300
`define SLD_SLOW_HALF     ((`SLD_CLK_HZ / 1000) * `SLD_SLOW_PERIOD_MS / 2)
`define SLD_FAST_HALF     ((`SLD_CLK_HZ / 1000) * `SLD_FAST_PERIOD_MS / 2)
`define SLD_REG_CTRL      12'h000
`define SLD_REG_ERRCODE   12'h004
`define SLD_REG_STATUS    12'h008
`define SLD_REG_IRQ_STAT  12'h00C
`define SLD_REG_IRQ_EN    12'h010
`define SLD_REG_IRQ_CLR   12'h014
`define SLD_REG_LEDS      12'h018
`define SLD_FN_DETECT     3'h0
`define SLD_FN_LIMIT      3'h1
`define SLD_FN_SPDSW      3'h2
`define SLD_FN_SPDSTEP    3'h3
`define SLD_FN_ACCDEC     3'h4
`define SLD_CTRL_FN_LSB   0
`define SLD_CTRL_LSPOS    3
`define SLD_CTRL_SEQERR   4
`define SLD_CTRL_RST      5'h00
`define SLD_ERR_MAX       5'h10
`endif

// ### logic/sld_top.v
// front-panel status led display of the position converter module
// Operation
// - error codes 1..7 on lower leds 0-4
// - error codes 8..16 on lower leds 0-4
// - error led steady, 1s or 0.3s blink
// - lower led 7 follows online status flag
// - leds a and b follow pulse outputs
// - unit-stop led lit when unit not ready
// - positioning: upper 4-7 brake, inpos, busy, error
// - upper 5-7 show limit channels when selected
//
// Our own choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "sld_consts.vh"
module sld_top #(
  parameter SLOW_HALF = `SLD_SLOW_HALF,
  parameter FAST_HALF = `SLD_FAST_HALF
) (
  input  wire        clk,
  input  wire        rstn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq,
  input  wire [4:0]  error_code,
  input  wire        module_error,
  input  wire        cpu_error,
  input  wire        online_status_flag,
  input  wire        unit_ready_flag,
  input  wire        pulse_a,
  input  wire        pulse_b,
  input  wire [7:0]  limit_channels,
  input  wire        forward_drive_output,
  input  wire        reverse_drive_output,
  input  wire        high_speed_select,
  input  wire        mid_low_speed_select,
  input  wire        brake_release,
  input  wire        in_position,
  input  wire        positioning_busy,
  input  wire        operation_error,
  input  wire        preset_input_1,
  input  wire        preset_input_2,
  output reg  [9:0]  upper_led,
  output reg  [4:0]  code_led,
  output reg         error_led,
  output reg         online_led,
  output reg         pulse_a_led,
  output reg         pulse_b_led,
  output reg         unit_stop_led
);
  wire [4:0] ctrl;
  wire       slow_blink;
  wire       fast_blink;
  wire [2:0] fn = ctrl[`SLD_CTRL_FN_LSB +: 3];
  wire       ls_pos = ctrl[`SLD_CTRL_LSPOS];
  wire       seq_err = ctrl[`SLD_CTRL_SEQERR];
  reg  [9:0] next_upper;
  reg        next_error;
  reg        err_seen;
  reg        ready_seen;
  reg        cpu_seen;

  sld_blink #(.HALF(SLOW_HALF)) u_slow (
    .clk   (clk),
    .rstn  (rstn),
    .blink (slow_blink)
  );
  sld_blink #(.HALF(FAST_HALF)) u_fast (
    .clk   (clk),
    .rstn  (rstn),
    .blink (fast_blink)
  );

  // upper row depends on operating function
  always @* begin
    next_upper = 10'h000;
    next_upper[8] = preset_input_1;
    next_upper[9] = preset_input_2;
    case (fn)
      `SLD_FN_DETECT: next_upper[7:0] = 8'h00;
      `SLD_FN_LIMIT:  next_upper[7:0] = limit_channels;
      `SLD_FN_SPDSW, `SLD_FN_SPDSTEP, `SLD_FN_ACCDEC: begin
        next_upper[0] = forward_drive_output;
        next_upper[1] = reverse_drive_output;
        if (fn != `SLD_FN_ACCDEC) begin
          next_upper[2] = high_speed_select;
          next_upper[3] = mid_low_speed_select;
        end
        next_upper[4] = brake_release;
        if (ls_pos)
          next_upper[7:5] = limit_channels[7:5];
        else
          next_upper[7:5] = {operation_error, positioning_busy, in_position};
      end
      default: next_upper[7:0] = 8'h00;
    endcase
  end

  // module error outranks program and cpu faults: the fault is local
  always @* begin
    if (module_error)
      next_error = 1'b1;
    else if (seq_err)
      next_error = slow_blink;
    else if (cpu_error)
      next_error = fast_blink;
    else
      next_error = 1'b0;
  end

  always @(posedge clk) begin
    if (!rstn) begin
      upper_led     <= 10'h000;
      code_led      <= 5'h00;
      error_led     <= 1'b0;
      online_led    <= 1'b0;
      pulse_a_led   <= 1'b0;
      pulse_b_led   <= 1'b0;
      unit_stop_led <= 1'b0;
      err_seen      <= 1'b0;
      ready_seen    <= 1'b1;
      cpu_seen      <= 1'b0;
    end else begin
      upper_led     <= next_upper;
      // out-of-range codes blank the row rather than show garbage
      code_led      <= (error_code <= `SLD_ERR_MAX) ? error_code : 5'h00;
      error_led     <= next_error;
      online_led    <= online_status_flag;
      pulse_a_led   <= pulse_a;
      pulse_b_led   <= pulse_b;
      unit_stop_led <= ~unit_ready_flag;
      err_seen      <= module_error;
      ready_seen    <= unit_ready_flag;
      cpu_seen      <= cpu_error;
    end
  end

  // edges only: a standing fault raises one event, not one per cycle
  wire [2:0] events = {cpu_error & ~cpu_seen,
                       ready_seen & ~unit_ready_flag,
                       module_error & ~err_seen};

  sld_apb u_apb (
    .clk       (clk),
    .rstn      (rstn),
    .psel      (psel),
    .penable   (penable),
    .pwrite    (pwrite),
    .paddr     (paddr),
    .pwdata    (pwdata),
    .prdata    (prdata),
    .pready    (pready),
    .pslverr   (pslverr),
    .err_code  (code_led),
    .status_in ({module_error, cpu_error, online_status_flag, unit_ready_flag,
                 pulse_b, pulse_a, preset_input_2, preset_input_1}),
    .leds_in   ({error_led, online_led, pulse_a_led, pulse_b_led, unit_stop_led,
                 code_led[3:0], upper_led}),
    .events    (events),
    .ctrl      (ctrl),
    .irq       (irq)
  );
endmodule

// ### verif/sld_monitor.sv
// port assertions of the status led display
`timescale 1ns/1ns
module sld_monitor (
  input wire       clk,
  input wire       rstn,
  input wire [4:0] error_code,
  input wire       module_error,
  input wire       cpu_error,
  input wire       online_status_flag,
  input wire       unit_ready_flag,
  input wire       pulse_a,
  input wire       pulse_b,
  input wire       preset_input_1,
  input wire       preset_input_2,
  input wire [9:0] upper_led,
  input wire [4:0] code_led,
  input wire       error_led,
  input wire       online_led,
  input wire       pulse_a_led,
  input wire       pulse_b_led,
  input wire       unit_stop_led
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // a long steady run under cpu error means a stuck blinker
  // only counted while the fault stands, so a dropped fault cannot trip it
  // limit assumes the short blink halves of the bench
  reg [4:0] quiet_cnt;
  reg       led_prev;
  always @(posedge clk) begin
    led_prev <= error_led;
    if (!rstn || !(cpu_error && !module_error) || error_led != led_prev)
      quiet_cnt <= 5'h00;
    else if (quiet_cnt != 5'h1F)
      quiet_cnt <= quiet_cnt + 5'h01;
  end
  sequence cpu_held;
    (cpu_error && !module_error)[*8];
  endsequence
  sequence led_not_stuck;
    quiet_cnt < 5'h14;
  endsequence
  online_follow_a:
    assert property ($past(rstn) |-> online_led == $past(online_status_flag)) else $error("online");
  pulse_follow_a:
    assert property ($past(rstn) |-> {pulse_a_led, pulse_b_led} == $past({pulse_a, pulse_b}))
      else $error("pulse leds");
  unit_stop_a:
    assert property ($past(rstn) |-> unit_stop_led == !$past(unit_ready_flag)) else $error("stop");
  preset_leds_a:
    assert property ($past(rstn) |-> upper_led[9:8] == $past({preset_input_2, preset_input_1}))
      else $error("preset leds");
  code_shown_a:
    assert property ($past(rstn) && $past(error_code) <= 5'h10 |-> code_led == $past(error_code))
      else $error("code leds");
  code_over_a:
    assert property ($past(rstn) && $past(error_code) > 5'h10 |-> code_led == 5'h00)
      else $error("code over");
  error_steady_a:
    assert property ($past(rstn) && $past(module_error) |-> error_led) else $error("error led");
  error_blink_a:
    assert property (cpu_held |-> led_not_stuck) else $error("error led stuck");
endmodule
bind sld_top sld_monitor mon (.*);

// ### verif/sld_source.sv
// model of the status sources feeding the display
`timescale 1ns/1ns
module sld_source (
  input  wire        clk,
  input  wire [28:0] want,
  output reg  [28:0] drv
);
  initial drv = 29'h0;
  // sources only move on clock edges, like the controller's scan
  always @(posedge clk) drv <= want;
endmodule

// ### verif/status_led_display_bench.sv
// self-checking bench of the status led display
`timescale 1ns/1ns
`include "sld_consts.vh"
module status_led_display_bench;
  logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, e;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, q;
  logic [28:0] want = 0, d;
  wire  [31:0] prdata;
  wire  [9:0]  upper_led;
  wire  [4:0]  code_led;
  wire         pready, pslverr, irq, error_led, online_led;
  wire         pulse_a_led, pulse_b_led, unit_stop_led;
  int          n_errors = 0, num_checks = 0;
  always #20 clk = ~clk;
  sld_source src (.clk(clk), .want(want), .drv(d));
  sld_top #(.SLOW_HALF(10), .FAST_HALF(3)) uut (.*, .error_code(d[4:0]), .module_error(d[5]),
    .cpu_error(d[6]), .online_status_flag(d[7]), .unit_ready_flag(d[8]), .pulse_a(d[9]),
    .pulse_b(d[10]), .limit_channels(d[18:11]), .forward_drive_output(d[19]),
    .reverse_drive_output(d[20]), .high_speed_select(d[21]), .mid_low_speed_select(d[22]),
    .brake_release(d[23]), .in_position(d[24]), .positioning_busy(d[25]),
    .operation_error(d[26]), .preset_input_1(d[27]), .preset_input_2(d[28]));
  task wt(input int n); repeat (n) @(posedge clk); endtask
  task chk(input string n, input logic [31:0] s, x);
    num_checks++;
    if (s !== x) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clk); psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge clk); penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata; e = pslverr; psel <= 0; penable <= 0;
  endtask
  task t_upper;
    logic [9:0] x;
    for (int f = 0; f < 10; f++) begin
      want <= f[0] ? 29'h155A9A05 : 29'h0AA5659A;
      apb(1, `SLD_REG_CTRL, {28'h0, f[0], 3'(f / 2)}); wt(3);
      x = {want[28:27], f < 2 ? 8'h00 : f < 4 ? want[18:11] : {f[0] ? want[18:16] : want[26:24],
        want[23], f > 7 ? 2'b00 : want[22:21], want[20:19]}};
      chk("upper", upper_led, x);
    end
  endtask
  task t_code;
    logic [3:0] sn;
    logic [3:0] lo;
    for (int c = 0; c < 21; c++) begin
      want <= {24'(c * 24'h359A3), 5'(c)};
      wt(3);
      sn = {online_led, pulse_b_led, pulse_a_led, unit_stop_led};
      lo = {want[7], want[10:9], ~want[8]};
      chk("code", code_led, c < 17 ? c : 0);
      chk("lower", sn, lo);
    end
    // code 13, online, ready, pulse a, preset 1; ctrl still accdec with limit select
    want <= 29'h0800038D;
    wt(3);
    apb(0, `SLD_REG_ERRCODE, 0);
    chk("errcode", q, 32'h0000000D);
    chk("slverr", e, 0);
    apb(0, `SLD_REG_STATUS, 0);
    chk("status", q, 32'h00000035);
    apb(0, `SLD_REG_LEDS, 0);
    chk("leds", q, 32'h00033500);
  endtask
  task t_err;
    int   n;
    logic p;
    want <= 29'h20;
    wt(3);
    chk("steady", error_led, 1);
    want <= 29'h40;
    n = 0;
    wt(3);
    p = error_led;
    repeat (12) begin
      @(posedge clk);
      n += (error_led != p);
      p = error_led;
    end
    chk("fast", n, 4);
    apb(1, `SLD_REG_CTRL, 32'h10);
    wt(2);
    n = 0;
    p = error_led;
    repeat (20) begin
      @(posedge clk);
      n += (error_led != p);
      p = error_led;
    end
    chk("slow", n, 2);
    apb(1, `SLD_REG_CTRL, 32'h0);
    want <= 29'h0;
    wt(3);
    chk("off", error_led, 0);
  endtask
  task t_irq;
    apb(0, `SLD_REG_CTRL, 0); chk("ctrl", q, 0);
    apb(1, `SLD_REG_IRQ_EN, 3); want <= 29'h100; wt(3); apb(1, `SLD_REG_IRQ_CLR, 7); wt(1);
    chk("irq", irq, 0); want <= 29'h120; wt(3); chk("irq", irq, 1);
    want <= 29'h0; wt(3); apb(0, `SLD_REG_IRQ_STAT, 0); chk("stat", q, 3);
    apb(1, `SLD_REG_IRQ_CLR, 3); wt(1); chk("irq", irq, 0);
    apb(1, `SLD_REG_IRQ_EN, 0); want <= 29'h20; wt(3); chk("mask", irq, 0);
    apb(0, `SLD_REG_IRQ_STAT, 0); chk("stat", q, 1);
    apb(0, 12'h01C, 0);
    chk("slverr", e, 1);
    chk("unmapped", q, 0);
    chk("pready", pready, 1);
    // module error falls while cpu error rises: only the cpu bit is new
    want <= 29'h40;
    wt(3);
    apb(0, `SLD_REG_IRQ_STAT, 0);
    chk("cpu event", q, 5);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // about 240 cycles of work against a 6000-cycle limit, so a margin of about 25 times
  initial begin #240000; n_errors++; complete_run; end
  initial begin
    wt(10); rstn <= 1;
    t_upper; t_code; t_err; t_irq;
    complete_run;
  end
endmodule
